/* hdl/ddc_dma_end.sv */
`include "ddc_consts.svh"
`default_nettype none
module ddc_dma_end #(
	parameter int RAM_AW = `DDC_RAM_AW
) (
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	ddc_link_if.dev                link,
	input  wire logic              ram_we_i,
	input  wire logic [RAM_AW-1:0] ram_addr_i,
	input  wire ddc_pkg::ddc_word_t ram_wdata_i,
	output var ddc_pkg::ddc_word_t ram_rdata_o,
	output logic                   busy_rd_o,
	output logic                   busy_wr_o
);
	import ddc_pkg::*;
	// Dual-port RAM: first port for user and write mover, second for read mover
	ddc_word_t   ram [2**RAM_AW];
	ddc_word_t   ram_q;
	ddc_state_t  st_q, st_d;
	ddc_dir_t    dir_q, dir_d;
	logic        rr_q, rr_d;
	logic [1:0]  k_q, k_d;
	ddc_word_t   cnt_q, cnt_d;
	logic [1:0]  act_q, act_d;
	logic [6:0]  last_q [2];
	logic [6:0]  last_d [2];
	logic [6:0]  nxt_q [2];
	logic [6:0]  nxt_d [2];
	// Descriptor stores, one per direction, three words each
	ddc_word_t   dsc_q [2][3];
	ddc_word_t   dsc_d [2][3];
	ddc_word_t   tbl, win;
	logic        p2_we;
	ddc_word_t   p2_addr, p2_data, p1_addr;
	// Two-entry buffer on returning read data
	ddc_word_t   buf_q [2];
	ddc_word_t   buf_d [2];
	logic [1:0]  bn_q, bn_d;
	logic        pop, bvalid;
	ddc_word_t   bdata;

	assign tbl         = dir_q == DDC_DIR_RD ? `DDC_RD_TABLE : `DDC_WR_TABLE;
	assign win         = (dir_q == DDC_DIR_RD ? `DDC_RD_WIN_BASE : `DDC_WR_WIN_BASE)
		+ {26'h0, nxt_q[dir_q][3:0], k_q};
	assign bvalid      = bn_q != 2'h0;
	assign bdata       = buf_q[0];
	assign link.rdat_ready = bn_q != 2'h2; // Stalls the link when both entries hold data
	assign link.prog_ready = !act_q[link.prog_dir];
	assign ram_rdata_o = ram_q;
	assign busy_rd_o   = act_q[0];
	assign busy_wr_o   = act_q[1];

	// Buffer next state; push from link, pop by the engine
	always_comb begin
		buf_d = buf_q;
		bn_d  = bn_q;
		if (pop) begin
			buf_d[0] = buf_q[1];
			bn_d     = bn_q - 2'h1;
		end
		if (link.rdat_valid && link.rdat_ready) begin
			buf_d[bn_d[0]] = link.rdat_data;
			bn_d           = bn_d + 2'h1;
		end
	end

	// Engine next state
	always_comb begin
		st_d    = st_q;
		dir_d   = dir_q;
		rr_d    = rr_q;
		k_d     = k_q;
		cnt_d   = cnt_q;
		act_d   = act_q;
		last_d  = last_q;
		nxt_d   = nxt_q;
		dsc_d   = dsc_q;
		pop     = 1'b0;
		p2_we   = 1'b0;
		p2_addr = dsc_q[dir_q][1] + cnt_q;
		p2_data = bdata;
		p1_addr = dsc_q[dir_q][0] + cnt_q;
		link.rreq_valid = 1'b0;
		link.rreq_addr  = tbl + {23'h0, nxt_q[dir_q], k_q};
		link.wreq_valid = 1'b0;
		link.wreq_addr  = dsc_q[dir_q][1] + cnt_q;
		link.wreq_data  = ram_q;
		// Last-ID write arms the flow from descriptor zero
		if (link.prog_valid && !act_q[link.prog_dir]) begin
			act_d[link.prog_dir]  = 1'b1;
			last_d[link.prog_dir] = link.prog_last;
			nxt_d[link.prog_dir]  = 7'h00;
		end
		case (st_q)
			S_IDLE: begin
				// One descriptor per turn, alternating when both flows run
				if (act_q != 2'h0) begin
					dir_d = (act_q == 2'h3) ? ddc_dir_t'(rr_q) : ddc_dir_t'(act_q[1]);
					rr_d  = !rr_q;
					k_d   = 2'h0;
					st_d  = S_FREQ;
				end
			end
			S_FREQ: begin
				link.rreq_valid = 1'b1;
				if (link.rreq_ready) st_d = S_FDAT;
			end
			S_FDAT: begin
				if (bvalid) begin
					pop = 1'b1;
					// Store chosen by window decode of the store address
					if (win >= `DDC_RD_WIN_BASE && win <= `DDC_RD_WIN_LAST)
						dsc_d[0][k_q] = bdata;
					else if (win >= `DDC_WR_WIN_BASE && win <= `DDC_WR_WIN_LAST)
						dsc_d[1][k_q] = bdata;
					k_d   = k_q + 2'h1;
					cnt_d = 32'h0000_0000;
					st_d  = S_FREQ;
					if (k_q == `DDC_W_SIZE) begin
						if (bdata == 32'h0000_0000) st_d = S_FLAG;
						else st_d = dir_q == DDC_DIR_RD ? S_RREQ : S_RAMRD;
					end
				end
			end
			S_RREQ: begin
				link.rreq_addr  = dsc_q[dir_q][0] + cnt_q;
				link.rreq_valid = 1'b1;
				if (link.rreq_ready) st_d = S_RDAT;
			end
			S_RDAT: begin
				if (bvalid) begin
					pop   = 1'b1;
					p2_we = 1'b1;
					cnt_d = cnt_q + 32'h0000_0001;
					st_d  = (cnt_d == dsc_q[dir_q][2]) ? S_FLAG : S_RREQ;
				end
			end
			S_RAMRD: st_d = S_HWR;
			S_HWR: begin
				link.wreq_valid = 1'b1;
				if (link.wreq_ready) begin
					cnt_d = cnt_q + 32'h0000_0001;
					st_d  = (cnt_d == dsc_q[dir_q][2]) ? S_FLAG : S_RAMRD;
				end
			end
			S_FLAG: begin
				// Only the last descriptor writes its done word
				if (nxt_q[dir_q] != last_q[dir_q]) begin
					nxt_d[dir_q] = nxt_q[dir_q] + 7'h01;
					st_d         = S_IDLE;
				end else begin
					link.wreq_valid = 1'b1;
					link.wreq_addr  = tbl + {23'h0, last_q[dir_q], `DDC_W_DONE};
					link.wreq_data  = `DDC_DONE_VAL;
					if (link.wreq_ready) st_d = S_MSI;
				end
			end
			S_MSI: begin
				link.wreq_valid = 1'b1;
				link.wreq_addr  = `DDC_MSI_ADDR;
				link.wreq_data  = `DDC_MSI_DATA | {31'h0, dir_q};
				if (link.wreq_ready) begin
					act_d[dir_q] = 1'b0;
					st_d         = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	// Registers of engine and buffer; clock enable freezes all of it
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_q   <= S_IDLE;
			dir_q  <= DDC_DIR_RD;
			rr_q   <= 1'b0;
			k_q    <= 2'h0;
			cnt_q  <= 32'h0000_0000;
			act_q  <= 2'h0;
			last_q <= '{default: 7'h00};
			nxt_q  <= '{default: 7'h00};
			dsc_q  <= '{default: '{default: 32'h0000_0000}};
			buf_q  <= '{default: 32'h0000_0000};
			bn_q   <= 2'h0;
			ram_q  <= 32'h0000_0000;
		end else if (ce_i) begin
			st_q   <= st_d;
			dir_q  <= dir_d;
			rr_q   <= rr_d;
			k_q    <= k_d;
			cnt_q  <= cnt_d;
			act_q  <= act_d;
			last_q <= last_d;
			nxt_q  <= nxt_d;
			dsc_q  <= dsc_d;
			buf_q  <= buf_d;
			bn_q   <= bn_d;
			// First port read; the engine owns it only in its read state
			ram_q  <= ram[st_q == S_RAMRD ? p1_addr[RAM_AW-1:0] : ram_addr_i];
		end
	end

	// RAM writes: user on the first port, read mover on the second
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && ram_we_i) ram[ram_addr_i] <= ram_wdata_i;
		if (ce_i && p2_we) ram[p2_addr[RAM_AW-1:0]] <= p2_data;
	end
endmodule : ddc_dma_end
`default_nettype wire

/* hdl/ddc_consts.svh */
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH
// Descriptor store windows on the internal memory-mapped bus (word addresses)
`define DDC_RD_WIN_BASE   32'h0801_0000
`define DDC_RD_WIN_LAST   32'h0801_1FFF
`define DDC_WR_WIN_BASE   32'h0801_2000
`define DDC_WR_WIN_LAST   32'h0801_3FFF
// Descriptor table: 128 entries of four words, IDs 0..127
`define DDC_DESC_COUNT    128
`define DDC_ID_W          7
`define DDC_W_SRC         2'h0
`define DDC_W_DST         2'h1
`define DDC_W_SIZE        2'h2
`define DDC_W_DONE        2'h3
`define DDC_DONE_VAL      32'h0000_0001
// Host memory word addresses of the two descriptor tables and the message target
`define DDC_RD_TABLE      32'h0000_0000
`define DDC_WR_TABLE      32'h0000_0200
`define DDC_MSI_ADDR      32'h0000_0FFF
`define DDC_MSI_DATA      32'h0000_0A00
// Dual-port RAM: 64 KB as 32-bit words
`define DDC_RAM_BYTES     65536
`define DDC_RAM_AW        14
`endif

/* hdl/ddc_pkg.sv */
`default_nettype none
package ddc_pkg;
	typedef enum logic {DDC_DIR_RD, DDC_DIR_WR} ddc_dir_t;
	typedef enum logic [3:0] {
		S_IDLE, S_FREQ, S_FDAT, S_RREQ, S_RDAT, S_RAMRD, S_HWR, S_FLAG, S_MSI
	} ddc_state_t;
	typedef logic [31:0] ddc_word_t;
endpackage : ddc_pkg
`default_nettype wire

/* hdl/ddc_link_if.sv */
`default_nettype none
interface ddc_link_if;
	import ddc_pkg::*;
	logic                prog_valid;
	logic                prog_ready;
	ddc_dir_t            prog_dir;
	logic [6:0]          prog_last;
	logic                rreq_valid;
	logic                rreq_ready;
	ddc_word_t           rreq_addr;
	logic                rdat_valid;
	logic                rdat_ready;
	ddc_word_t           rdat_data;
	logic                wreq_valid;
	logic                wreq_ready;
	ddc_word_t           wreq_addr;
	ddc_word_t           wreq_data;
	modport dev (input prog_valid, prog_dir, prog_last, rreq_ready, rdat_valid, rdat_data,
		wreq_ready, output prog_ready, rreq_valid, rreq_addr, rdat_ready, wreq_valid,
		wreq_addr, wreq_data);
	modport hst (output prog_valid, prog_dir, prog_last, rreq_ready, rdat_valid, rdat_data,
		wreq_ready, input prog_ready, rreq_valid, rreq_addr, rdat_ready, wreq_valid,
		wreq_addr, wreq_data);
endinterface : ddc_link_if
`default_nettype wire

/* hdl/ddc_host_end.sv */
`include "ddc_consts.svh"
`default_nettype none
// Host side: system memory, descriptor programming and completion polling
module ddc_host_end #(
	parameter int MEM_AW = 12
) (
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ce_i,
	ddc_link_if.hst                link,
	input  wire logic              mem_we_i,
	input  wire logic [MEM_AW-1:0] mem_addr_i,
	input  wire ddc_pkg::ddc_word_t mem_wdata_i,
	output var ddc_pkg::ddc_word_t mem_rdata_o,
	input  wire logic              start_rd_i,
	input  wire logic              start_wr_i,
	input  wire logic [6:0]        last_id_i,
	output logic                   done_rd_o,
	output logic                   done_wr_o,
	output logic                   run_done_o
);
	import ddc_pkg::*;
	ddc_word_t  mem [2**MEM_AW];
	logic       prd_q, prd_d, pwr_q, pwr_d, drd_q, drd_d, dwr_q, dwr_d, rv_q, rv_d;
	logic [6:0] last_q, last_d;
	ddc_word_t  rdat_q, rdat_d, mq_q, flag_rd, flag_wr;
	logic       snoop;

	// Completion flag word addresses of the last descriptor in each table
	assign flag_rd = `DDC_RD_TABLE + {23'h0, last_q, `DDC_W_DONE};
	assign flag_wr = `DDC_WR_TABLE + {23'h0, last_q, `DDC_W_DONE};
	assign snoop   = link.wreq_valid && link.wreq_data[0];

	// Read first, write after, when both are requested together
	assign link.prog_valid = prd_q || pwr_q;
	assign link.prog_dir   = prd_q ? DDC_DIR_RD : DDC_DIR_WR;
	assign link.prog_last  = last_q;
	assign link.rreq_ready = !rv_q;
	assign link.rdat_valid = rv_q;
	assign link.rdat_data  = rdat_q;
	assign link.wreq_ready = 1'b1;
	assign mem_rdata_o     = mq_q;
	assign done_rd_o       = drd_q;
	assign done_wr_o       = dwr_q;
	assign run_done_o      = drd_q && dwr_q;

	// Next state of programming, polling and read answer
	always_comb begin
		prd_d  = prd_q;
		pwr_d  = pwr_q;
		last_d = last_q;
		drd_d  = drd_q;
		dwr_d  = dwr_q;
		rv_d   = rv_q;
		rdat_d = rdat_q;
		if (link.prog_valid && link.prog_ready) begin
			if (prd_q) prd_d = 1'b0;
			else pwr_d = 1'b0;
		end
		// Table must already be in memory when a start is given
		if (start_rd_i || start_wr_i) begin
			prd_d  = start_rd_i;
			pwr_d  = start_wr_i;
			last_d = last_id_i;
			drd_d  = !start_rd_i && drd_q;
			dwr_d  = !start_wr_i && dwr_q;
		end
		// Flag seen in the last descriptor ends that flow
		if (snoop && link.wreq_addr == flag_rd) drd_d = 1'b1;
		if (snoop && link.wreq_addr == flag_wr) dwr_d = 1'b1;
		if (link.rreq_valid && !rv_q) begin
			rv_d   = 1'b1;
			rdat_d = mem[link.rreq_addr[MEM_AW-1:0]];
		end else if (rv_q && link.rdat_ready) begin
			rv_d = 1'b0;
		end
	end

	// Registers; registered memory read for the user port
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			prd_q  <= 1'b0;
			pwr_q  <= 1'b0;
			last_q <= 7'h00;
			drd_q  <= 1'b0;
			dwr_q  <= 1'b0;
			rv_q   <= 1'b0;
			rdat_q <= 32'h0000_0000;
			mq_q   <= 32'h0000_0000;
		end else if (ce_i) begin
			prd_q  <= prd_d;
			pwr_q  <= pwr_d;
			last_q <= last_d;
			drd_q  <= drd_d;
			dwr_q  <= dwr_d;
			rv_q   <= rv_d;
			rdat_q <= rdat_d;
			mq_q   <= mem[mem_addr_i];
		end
	end

	// Host memory; the user port wins a same-cycle collision with the link
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
		else if (ce_i && link.wreq_valid) mem[link.wreq_addr[MEM_AW-1:0]] <= link.wreq_data;
	end
endmodule : ddc_host_end
`default_nettype wire

/* tb/ddc_link_monitor.sv */
`include "ddc_consts.svh"
`default_nettype none
// Watches the link between the host end and the engine end
module ddc_link_monitor (
	input wire logic              sys_clk_i,
	input wire logic              resetn_i,
	input wire logic              prog_valid,
	input wire logic              prog_ready,
	input wire ddc_pkg::ddc_dir_t prog_dir,
	input wire logic [6:0]        prog_last,
	input wire logic              rreq_valid,
	input wire logic              rreq_ready,
	input wire ddc_pkg::ddc_word_t rreq_addr,
	input wire logic              rdat_valid,
	input wire logic              rdat_ready,
	input wire ddc_pkg::ddc_word_t rdat_data,
	input wire logic              wreq_valid,
	input wire logic              wreq_ready,
	input wire ddc_pkg::ddc_word_t wreq_addr,
	input wire ddc_pkg::ddc_word_t wreq_data
);
	import ddc_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// Offered words must not move before they are taken
	prog_hold_a: assert property (prog_valid && !prog_ready
		|=> prog_valid && $stable(prog_last))
		else $error("last id changed before taken");
	rreq_hold_a: assert property (rreq_valid && !rreq_ready
		|=> rreq_valid && $stable(rreq_addr))
		else $error("read request changed before taken");
	rdat_hold_a: assert property (rdat_valid && !rdat_ready
		|=> rdat_valid && $stable(rdat_data))
		else $error("read answer changed before taken");
	read_answer_a: assert property (rreq_valid && rreq_ready |=> rdat_valid)
		else $error("read answer late");
	// Table writes carry only the done value, in the done slot
	done_value_a: assert property (wreq_valid && wreq_addr < 32'h0000_0400
		|-> wreq_addr[1:0] == 2'h3 && wreq_data == `DDC_DONE_VAL)
		else $error("bad write into descriptor table");
	msg_value_a: assert property (wreq_valid && wreq_addr == `DDC_MSI_ADDR
		|-> wreq_data[31:1] == 31'h0000_0500)
		else $error("bad message data");
	msg_follows_a: assert property (wreq_valid && wreq_ready && wreq_addr < 32'h0000_0400
		|=> ##[0:8] (wreq_valid && wreq_addr == `DDC_MSI_ADDR))
		else $error("no message after done write");
	fetch_start_a: assert property (prog_valid && prog_ready |-> ##[1:40] rreq_valid)
		else $error("run did not start fetching");
	stall_c: cover property (rdat_valid && !rdat_ready);
	both_c: cover property (prog_valid && prog_ready ##1 prog_valid && prog_ready);
	write_dir_c: cover property (prog_valid && prog_ready && prog_dir == DDC_DIR_WR);
	done_c: cover property (wreq_valid && wreq_addr == `DDC_MSI_ADDR);
endmodule : ddc_link_monitor
`default_nettype wire

/* tb/testbench.sv */
`include "ddc_consts.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ddc_pkg::*;
	// Row: direction, last ID, words per descriptor, expected {done_rd, done_wr} after it
	typedef struct packed {logic dir; logic [6:0] lst; logic [3:0] sz; logic [1:0] dn;} ddc_row_t;
	logic        sys_clk, resetn, ce, mwe, rwe, srd, swr, drd, dwr, rdone, brd, bwr;
	logic [11:0] maddr;
	logic [13:0] raddr;
	logic [6:0]  last;
	ddc_word_t   mwd, mrd, rwd, rrd;
	int          err_total, total_checks, cyc = 0;
	ddc_row_t    rows [4] = '{'{0, 0, 1, 2'h2}, '{0, 2, 3, 2'h2}, '{1, 0, 1, 2'h3}, '{1, 2, 2, 2'h3}};
	ddc_link_if link_bus ();
	ddc_host_end #(.MEM_AW(12)) u_ddc_host_end (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.ce_i(ce), .link(link_bus), .mem_we_i(mwe), .mem_addr_i(maddr), .mem_wdata_i(mwd),
		.mem_rdata_o(mrd), .start_rd_i(srd), .start_wr_i(swr), .last_id_i(last),
		.done_rd_o(drd), .done_wr_o(dwr), .run_done_o(rdone));
	ddc_dma_end u_ddc_dma_end (.sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(ce),
		.link(link_bus), .ram_we_i(rwe), .ram_addr_i(raddr), .ram_wdata_i(rwd),
		.ram_rdata_o(rrd), .busy_rd_o(brd), .busy_wr_o(bwr));
	ddc_link_monitor u_ddc_link_monitor (.sys_clk_i(sys_clk), .resetn_i(resetn),
		.prog_valid(link_bus.prog_valid), .prog_ready(link_bus.prog_ready),
		.prog_dir(link_bus.prog_dir), .prog_last(link_bus.prog_last),
		.rreq_valid(link_bus.rreq_valid), .rreq_ready(link_bus.rreq_ready),
		.rreq_addr(link_bus.rreq_addr), .rdat_valid(link_bus.rdat_valid),
		.rdat_ready(link_bus.rdat_ready), .rdat_data(link_bus.rdat_data),
		.wreq_valid(link_bus.wreq_valid), .wreq_ready(link_bus.wreq_ready),
		.wreq_addr(link_bus.wreq_addr), .wreq_data(link_bus.wreq_data));
	// Free running clock
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	// Hang guard, well above the longest run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic ddc_word_t pat(input int a);
		return 32'h3C00_0000 + a;
	endfunction : pat
	// Word write into host memory (h) or engine RAM
	task automatic put(input logic h, input int a, input ddc_word_t d);
		@(negedge sys_clk);
		if (h) begin mwe = 1; maddr = a[11:0]; mwd = d; end
		else begin rwe = 1; raddr = a[13:0]; rwd = d; end
		@(negedge sys_clk);
		mwe = 0;
		rwe = 0;
	endtask : put
	// Registered read: address before the edge, data after it
	task automatic get(input logic h, input int a, output ddc_word_t d);
		@(negedge sys_clk);
		maddr = a[11:0];
		raddr = a[13:0];
		@(negedge sys_clk);
		d = h ? mrd : rrd;
	endtask : get
	// Descriptor plus source data plus a sentinel past the destination
	task automatic prep(input logic dir, input int id, input int sz);
		int s, d, t;
		s = (dir ? 'h800 : 'h400) + id * 8;
		d = (dir ? 'h600 : 'h100) + id * 8;
		t = (dir ? `DDC_WR_TABLE : `DDC_RD_TABLE) + id * 4;
		for (int w = 0; w < sz; w++) put(!dir, s + w, pat(s + w));
		put(dir, d + sz, 32'hDEAD_BEEF);
		put(1, t, s);
		put(1, t + 1, d);
		put(1, t + 2, sz);
		put(1, t + 3, 0);
	endtask : prep
	task automatic verify(input logic dir, input int id, input int sz, input int lst);
		ddc_word_t v;
		int s, d;
		s = (dir ? 'h800 : 'h400) + id * 8;
		d = (dir ? 'h600 : 'h100) + id * 8;
		for (int w = 0; w <= sz; w++) begin
			get(dir, d + w, v);
			chk("moved word", v, (w < sz) ? pat(s + w) : 32'hDEAD_BEEF);
		end
		get(1, (dir ? `DDC_WR_TABLE : `DDC_RD_TABLE) + id * 4 + 3, v);
		chk("done word", v, (id == lst) ? 1 : 0);
	endtask : verify
	// Start pulse, then bounded wait for the done flags
	task automatic run(input logic rd, input logic wr, input int l);
		@(negedge sys_clk);
		srd = rd;
		swr = wr;
		last = l[6:0];
		@(negedge sys_clk);
		srd = 0;
		swr = 0;
		for (int i = 0; i < 4000 && !((drd === 1'b1 || !rd) && (dwr === 1'b1 || !wr)); i++)
			@(negedge sys_clk);
		repeat (12) @(negedge sys_clk);
		chk("done flags", {drd | !rd, dwr | !wr}, 2'h3);
		chk("busy flags", {brd, bwr}, 2'h0);
	endtask : run
	initial begin
		resetn = 0;
		ce = 1;
		{mwe, rwe, srd, swr, last, maddr, raddr, mwd, rwd} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (4) @(negedge sys_clk);
		resetn = 1;
		chk("reset flags", {drd, dwr, rdone, brd, bwr}, 5'h00);
		// Ordinary single-direction runs
		foreach (rows[r]) begin
			for (int i = 0; i <= rows[r].lst; i++) prep(rows[r].dir, i, rows[r].sz);
			run(!rows[r].dir, rows[r].dir, rows[r].lst);
			chk("row flags", {drd, dwr}, rows[r].dn);
			for (int i = 0; i <= rows[r].lst; i++) verify(rows[r].dir, i, rows[r].sz, rows[r].lst);
		end
		// Both flows started together; status writes share one path
		prep(0, 0, 2);
		prep(1, 0, 2);
		run(1, 1, 0);
		chk("run done", rdone, 1'b1);
		verify(0, 0, 2, 0);
		verify(1, 0, 2, 0);
		// Full table up to the highest ID, empty descriptors
		for (int i = 0; i < `DDC_DESC_COUNT; i++) prep(0, i, 0);
		run(1, 0, 127);
		verify(0, 0, 0, 127);
		verify(0, 127, 0, 127);
		// Clock enable low freezes both ends in mid-run
		@(negedge sys_clk);
		srd = 1;
		last = 7'h00;
		@(negedge sys_clk);
		srd = 0;
		repeat (3) @(negedge sys_clk);
		ce = 0;
		repeat (20) @(negedge sys_clk);
		chk("frozen run", {brd, drd}, 2'h2);
		// A second last-ID write waits while its direction is busy
		ce = 1;
		srd = 1;
		@(negedge sys_clk);
		srd = 0;
		chk("refused id", {link_bus.prog_valid, link_bus.prog_ready}, 2'h2);
		repeat (60) @(negedge sys_clk);
		chk("restart done", {drd, brd, link_bus.prog_valid}, 3'h4);
		// Reset in mid-run drops every flag and idles the link
		@(negedge sys_clk);
		srd = 1;
		last = 7'h7F;
		@(negedge sys_clk);
		srd = 0;
		repeat (20) @(negedge sys_clk);
		resetn = 0;
		repeat (4) @(negedge sys_clk);
		resetn = 1;
		chk("reset mid-run", {drd, dwr, rdone, brd, bwr}, 5'h00);
		repeat (2) @(negedge sys_clk);
		chk("idle prog", link_bus.prog_valid, 1'b0);
		chk("idle reqs", {link_bus.rreq_valid, link_bus.wreq_valid}, 2'h0);
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
